// ===== core/lamp_burst_dimming_supervisor_cfg.svh
// Constants for the lamp burst dimming supervisor.
`ifndef LAMP_BURST_DIMMING_SUPERVISOR_CFG_SVH
`define LAMP_BURST_DIMMING_SUPERVISOR_CFG_SVH
`define CLK_HZ              250000000
`define MIN_ON_COUNT        8'h08
`define RAMP_TOP            8'hff
`define SENSE_DISABLE_LEVEL 8'h1a
`define QUALIFY_CYCLES      6'h30
`define BLANK_MAX_SEC       5
`define BLANK_MAX_CYCLES    (`BLANK_MAX_SEC * `CLK_HZ)
`define ADDR_CTRL           12'h000
`define ADDR_BRIGHT         12'h004
`define ADDR_DIVIDER        12'h008
`define ADDR_BLANK          12'h00c
`define ADDR_STATUS         12'h010
`define ADDR_IRQ_STATUS     12'h014
`define ADDR_IRQ_CLEAR      12'h018
`define ADDR_IRQ_ENABLE     12'h01c
`define CTRL_RESET          32'h0000_0000
`define BRIGHT_RESET        8'h00
`define DIVIDER_RESET       16'h0079
`define BLANK_RESET         32'h0000_0fa0
`define IRQ_FAULT_BIT       0
`define IRQ_PERIOD_BIT      1
`define IRQ_ARMED_BIT       2
`endif

// ===== core/lamp_burst_dimming_supervisor_pkg.sv
// Types shared by the lamp burst dimming supervisor.
package lamp_burst_dimming_supervisor_pkg;
  typedef struct packed {
    logic [11:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_rsp_t;
  typedef enum logic [1:0] {
    ST_OFF,
    ST_BLANK,
    ST_RUN,
    ST_FAULT
  } sup_state_t;
endpackage : lamp_burst_dimming_supervisor_pkg

// ===== core/lamp_burst_dimming_supervisor.sv
// Burst dimming PWM with open-lamp fault supervision behind an AXI4-Lite slave.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`include "lamp_burst_dimming_supervisor_cfg.svh"
module lamp_burst_dimming_supervisor (
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  input  wire logic                                   enable,
  input  wire logic                                   supply_good,
  input  wire logic                                   lamp_sense,
  input  wire logic                                   burst_clock_select,
  input  wire lamp_burst_dimming_supervisor_pkg::axil_req_t axi_req,
  output      lamp_burst_dimming_supervisor_pkg::axil_rsp_t axi_rsp,
  output      logic                                   drive_out,
  output      logic                                   irq
);
  import lamp_burst_dimming_supervisor_pkg::*;

  logic        ext_clk_mode_q;
  logic [7:0]  brightness_level_q;
  logic [15:0] divider_q;
  logic [31:0] fault_blank_delay_q;
  logic [2:0]  irq_status_q;
  logic [2:0]  irq_enable_q;
  logic [15:0] div_cnt_q;
  logic        ext_clk_q;
  logic        step_en;
  logic [7:0]  ramp_q;
  logic        ramp_down_q;
  logic        pwm_on;
  sup_state_t  state_q;
  logic [31:0] blank_cnt_q;
  logic [5:0]  qual_cnt_q;
  logic        active;
  logic        sense_allowed;
  logic        fault_event;
  logic        period_event;
  logic        armed_event;
  logic        aw_done_q;
  logic        w_done_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;
  logic [31:0] rd_data;
  logic        rd_hit;
  logic [2:0]  irq_clear;

  // Merges the written byte lanes into an old register value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  assign active = enable && supply_good;

  // The counter steps on the internal divider or on each rising edge of the external clock.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt_q <= 16'h0000;
      ext_clk_q <= 1'b0;
    end
    else
    begin
      ext_clk_q <= burst_clock_select;
      if (ext_clk_mode_q || div_cnt_q >= divider_q)
      begin
        div_cnt_q <= 16'h0000;
      end
      else
      begin
        div_cnt_q <= div_cnt_q + 16'h0001;
      end
    end
  end

  assign step_en = ext_clk_mode_q ? (burst_clock_select && !ext_clk_q)
                                  : (div_cnt_q >= divider_q);

  // Up 256 steps then down 256 steps: 512 steps per burst period.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ramp_q      <= 8'h00;
      ramp_down_q <= 1'b0;
    end
    else if (step_en)
    begin
      if (!ramp_down_q)
      begin
        if (ramp_q == `RAMP_TOP)
        begin
          ramp_down_q <= 1'b1;
        end
        else
        begin
          ramp_q <= ramp_q + 8'h01;
        end
      end
      else
      begin
        if (ramp_q == 8'h00)
        begin
          ramp_down_q <= 1'b0;
        end
        else
        begin
          ramp_q <= ramp_q - 8'h01;
        end
      end
    end
  end

  assign pwm_on = (ramp_q < `MIN_ON_COUNT)
               || (brightness_level_q == 8'hff)
               || (ramp_q < brightness_level_q);
  assign period_event = step_en && ramp_down_q && ramp_q == 8'h00;

  // Comparator output arrives as a level; low means lamp current below 3 V.
  assign sense_allowed = brightness_level_q >= `SENSE_DISABLE_LEVEL;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= ST_OFF;
      blank_cnt_q <= 32'h0000_0000;
      qual_cnt_q  <= 6'h00;
    end
    else if (!active)
    begin
      state_q     <= ST_OFF;
      blank_cnt_q <= 32'h0000_0000;
      qual_cnt_q  <= 6'h00;
    end
    else
    begin
      unique case (state_q)
        ST_OFF:
        begin
          state_q     <= ST_BLANK;
          blank_cnt_q <= 32'h0000_0000;
        end
        ST_BLANK:
        begin
          if (blank_cnt_q >= fault_blank_delay_q)
          begin
            state_q <= ST_RUN;
          end
          else
          begin
            blank_cnt_q <= blank_cnt_q + 32'h0000_0001;
          end
        end
        ST_RUN:
        begin
          if (!lamp_sense && sense_allowed)
          begin
            if (qual_cnt_q == `QUALIFY_CYCLES - 6'h01)
            begin
              state_q <= ST_FAULT;
            end
            else
            begin
              qual_cnt_q <= qual_cnt_q + 6'h01;
            end
          end
          else
          begin
            qual_cnt_q <= 6'h00;
          end
        end
        ST_FAULT:
        begin
          state_q <= ST_FAULT;
        end
      endcase
    end
  end

  assign fault_event = active && state_q == ST_RUN && !lamp_sense && sense_allowed
                    && qual_cnt_q == `QUALIFY_CYCLES - 6'h01;
  assign armed_event = active && state_q == ST_BLANK && blank_cnt_q >= fault_blank_delay_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drive_out <= 1'b0;
    end
    else
    begin
      drive_out <= active && state_q != ST_FAULT && state_q != ST_OFF && pwm_on;
    end
  end

  assign wr_fire = aw_done_q && w_done_q && !axi_rsp.bvalid;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_done_q      <= 1'b0;
      w_done_q       <= 1'b0;
      aw_addr_q      <= 12'h000;
      w_data_q       <= 32'h0000_0000;
      w_strb_q       <= 4'h0;
      axi_rsp.awready <= 1'b0;
      axi_rsp.wready  <= 1'b0;
      axi_rsp.bvalid  <= 1'b0;
      axi_rsp.bresp   <= 2'h0;
      axi_rsp.arready <= 1'b0;
      axi_rsp.rvalid  <= 1'b0;
      axi_rsp.rdata   <= 32'h0000_0000;
      axi_rsp.rresp   <= 2'h0;
    end
    else
    begin
      axi_rsp.awready <= !aw_done_q && !axi_rsp.awready && axi_req.awvalid;
      axi_rsp.wready  <= !w_done_q && !axi_rsp.wready && axi_req.wvalid;
      if (axi_req.awvalid && axi_rsp.awready)
      begin
        aw_done_q <= 1'b1;
        aw_addr_q <= axi_req.awaddr;
      end
      if (axi_req.wvalid && axi_rsp.wready)
      begin
        w_done_q <= 1'b1;
        w_data_q <= axi_req.wdata;
        w_strb_q <= axi_req.wstrb;
      end
      if (wr_fire)
      begin
        axi_rsp.bvalid <= 1'b1;
        axi_rsp.bresp  <= (aw_addr_q <= `ADDR_IRQ_ENABLE && aw_addr_q[1:0] == 2'b00
                           && aw_addr_q != `ADDR_STATUS && aw_addr_q != `ADDR_IRQ_STATUS) ? 2'h0 : 2'h2;
      end
      else if (axi_rsp.bvalid && axi_req.bready)
      begin
        axi_rsp.bvalid <= 1'b0;
        aw_done_q      <= 1'b0;
        w_done_q       <= 1'b0;
      end
      axi_rsp.arready <= axi_req.arvalid && !axi_rsp.arready && !axi_rsp.rvalid;
      if (axi_req.arvalid && axi_rsp.arready)
      begin
        axi_rsp.rvalid <= 1'b1;
        axi_rsp.rdata  <= rd_data;
        axi_rsp.rresp  <= rd_hit ? 2'h0 : 2'h2;
      end
      else if (axi_rsp.rvalid && axi_req.rready)
      begin
        axi_rsp.rvalid <= 1'b0;
      end
    end
  end

  assign irq_clear = (wr_fire && aw_addr_q == `ADDR_IRQ_CLEAR && w_strb_q[0]) ? w_data_q[2:0] : 3'h0;

  // Software registers; irq status sets win over a clear in the same cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_clk_mode_q      <= 1'b0;
      brightness_level_q  <= `BRIGHT_RESET;
      divider_q           <= `DIVIDER_RESET;
      fault_blank_delay_q <= `BLANK_RESET;
      irq_enable_q        <= 3'h0;
      irq_status_q        <= 3'h0;
    end
    else
    begin
      if (wr_fire)
      begin
        unique case (aw_addr_q)
          `ADDR_CTRL:       ext_clk_mode_q      <= 1'(merge({31'h0, ext_clk_mode_q}, w_data_q, w_strb_q));
          `ADDR_BRIGHT:     brightness_level_q  <= 8'(merge({24'h0, brightness_level_q}, w_data_q, w_strb_q));
          `ADDR_DIVIDER:    divider_q           <= 16'(merge({16'h0, divider_q}, w_data_q, w_strb_q));
          `ADDR_BLANK:
          begin
            fault_blank_delay_q <= (merge(fault_blank_delay_q, w_data_q, w_strb_q) > `BLANK_MAX_CYCLES)
                                   ? 32'(`BLANK_MAX_CYCLES) : merge(fault_blank_delay_q, w_data_q, w_strb_q);
          end
          `ADDR_IRQ_ENABLE: irq_enable_q        <= 3'(merge({29'h0, irq_enable_q}, w_data_q, w_strb_q));
          default:          ;
        endcase
      end
      irq_status_q <= (irq_status_q & ~irq_clear) | {armed_event, period_event, fault_event};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irq_status_q & irq_enable_q);
    end
  end

  always_comb
  begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (axi_req.araddr)
      `ADDR_CTRL:       rd_data = {31'h0, ext_clk_mode_q};
      `ADDR_BRIGHT:     rd_data = {24'h0, brightness_level_q};
      `ADDR_DIVIDER:    rd_data = {16'h0, divider_q};
      `ADDR_BLANK:      rd_data = fault_blank_delay_q;
      `ADDR_STATUS:     rd_data = {26'h0, ramp_down_q, drive_out, active, sense_allowed, state_q};
      `ADDR_IRQ_STATUS: rd_data = {29'h0, irq_status_q};
      `ADDR_IRQ_CLEAR:  rd_data = 32'h0000_0000;
      `ADDR_IRQ_ENABLE: rd_data = {29'h0, irq_enable_q};
      default:          rd_hit = 1'b0;
    endcase
  end

endmodule : lamp_burst_dimming_supervisor

// ===== tb/lamp_burst_dimming_supervisor_props.sv
// Port assertions for the lamp burst dimming supervisor.
module lamp_burst_dimming_supervisor_props
  import lamp_burst_dimming_supervisor_pkg::*;
(
  input logic      clk,
  input logic      rst_n,
  input logic      enable,
  input logic      supply_good,
  input logic      lamp_sense,
  input logic      burst_clock_select,
  input axil_req_t axi_req,
  input axil_rsp_t axi_rsp,
  input logic      drive_out,
  input logic      irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  en_off_a: assert property (!enable [*4] |-> !drive_out)
    else $error("drive on while disabled");
  sup_off_a: assert property (!supply_good [*4] |-> !drive_out)
    else $error("drive on in lockout");
  aw_pulse_a: assert property (axi_rsp.awready |=> !axi_rsp.awready)
    else $error("awready held");
  ar_pulse_a: assert property (axi_rsp.arready |=> !axi_rsp.arready)
    else $error("arready held");
  b_soon_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |-> ##[1:2] axi_rsp.bvalid) else $error("no write response");
  r_soon_a: assert property (axi_req.arvalid && axi_rsp.arready |-> ##[1:2] axi_rsp.rvalid)
    else $error("no read response");
  b_done_a: assert property (axi_rsp.bvalid && axi_req.bready |=> $fell(axi_rsp.bvalid))
    else $error("bvalid held");
  r_done_a: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
    else $error("rvalid held");
endmodule : lamp_burst_dimming_supervisor_props
bind lamp_burst_dimming_supervisor lamp_burst_dimming_supervisor_props i_props (.clk, .rst_n, .enable,
  .supply_good, .lamp_sense, .burst_clock_select, .axi_req, .axi_rsp, .drive_out, .irq);

// ===== tb/lamp_load.sv
// Lamp load model behind the drive transistors.
module lamp_load #(
  parameter int DECAY = 4096
) (
  input  logic clk,
  input  logic rst_n,
  input  logic drive_out,
  input  logic open_lamp,
  output logic lamp_sense
);
  timeunit 1ns;
  timeprecision 1ps;
  int dark_q;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      dark_q <= DECAY;
    else if (drive_out)
      dark_q <= 0;
    else if (dark_q < DECAY)
      dark_q <= dark_q + 1;
  // Sense only reports current once the lamp was struck, and fades after a long dark spell.
  assign lamp_sense = !open_lamp && (dark_q < DECAY);
endmodule : lamp_load

// ===== tb/tb.sv
// Self-checking bench for the lamp burst dimming supervisor.
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t bad value", $time); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lamp_burst_dimming_supervisor_pkg::*;
  logic        clk, rst_n, enable, supply_good, open_lamp, lamp_sense, drive_out, irq;
  logic [1:0]  ec, r;
  logic [31:0] d;
  axil_req_t   q;
  axil_rsp_t   s;
  int          mismatches, n_checks, h;
  logic [11:0] ra [5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h020};
  logic [33:0] rv [5] = '{34'h0, 34'h0, 34'h79, 34'hfa0, 34'h2_0000_0000};
  logic [7:0]  bl [5] = '{8'h00, 8'h04, 8'h10, 8'h80, 8'hff};
  int          he [5] = '{16, 16, 32, 256, 512};
  lamp_burst_dimming_supervisor i_lamp_burst_dimming_supervisor (.clk, .rst_n, .enable, .supply_good,
    .lamp_sense, .burst_clock_select(ec[1]), .axi_req(q), .axi_rsp(s), .drive_out, .irq);
  lamp_load i_lamp_load (.clk, .rst_n, .drive_out, .open_lamp, .lamp_sense);
  // The external burst clock runs at a quarter of the system clock.
  always @(posedge clk) ec <= rst_n ? ec + 2'h1 : 2'h0;
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task tmo;
    mismatches++;
    $display("ERROR %0t timeout", $time);
    stop_test();
  endtask : tmo
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] e);
    logic [2:0] p;
    logic [2:0] c;
    @(posedge clk);
    p = 3'b111;
    q.awaddr <= a;
    q.wdata <= v;
    q.wstrb <= 4'hf;
    q.awvalid <= 1'b1;
    q.wvalid <= 1'b1;
    q.bready <= 1'b1;
    for (int i = 0; p[2]; i++)
    begin
      if (i > 99) tmo();
      @(negedge clk);
      c = {s.bvalid, s.wready, s.awready} & p;
      e = s.bresp;
      @(posedge clk);
      p = p & ~c;
      if (c[0]) q.awvalid <= 1'b0;
      if (c[1]) q.wvalid <= 1'b0;
      if (c[2]) q.bready <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] e);
    logic [1:0] p;
    logic [1:0] c;
    @(posedge clk);
    p = 2'b11;
    q.araddr <= a;
    q.arvalid <= 1'b1;
    q.rready <= 1'b1;
    for (int i = 0; p[1]; i++)
    begin
      if (i > 99) tmo();
      @(negedge clk);
      c = {s.rvalid, s.arready} & p;
      v = s.rdata;
      e = s.rresp;
      @(posedge clk);
      p = p & ~c;
      if (c[0]) q.arvalid <= 1'b0;
      if (c[1]) q.rready <= 1'b0;
    end
  endtask : rd
  task automatic meas(input int n, output int k);
    k = 0;
    repeat (n)
    begin
      @(negedge clk);
      k += (drive_out === 1'b1);
    end
  endtask : meas
  task automatic wirq(input int n);
    for (int i = 0; i < n && irq !== 1'b1; i++)
      @(negedge clk);
    `CHK(irq, 1'b1)
    if (irq !== 1'b1) stop_test();
  endtask : wirq
  initial
  begin
    rst_n = 1'b0;
    enable = 1'b0;
    supply_good = 1'b1;
    open_lamp = 1'b0;
    q = '0;
    mismatches = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    foreach (ra[k])
    begin
      rd(ra[k], d, r);
      `CHK({r, d}, rv[k])
    end
    wr(12'h010, 32'h1, r);
    `CHK(r, 2'h2)
    wr(12'h00c, 32'hffff_ffff, r);
    rd(12'h00c, d, r);
    `CHK(d, 32'h4a81_7c80)
    wr(12'h008, 32'h0, r);
    wr(12'h00c, 32'ha, r);
    wr(12'h01c, 32'h1, r);
    enable <= 1'b1;
    $display("registers done");
    foreach (bl[k])
    begin
      wr(12'h004, {24'h0, bl[k]}, r);
      meas(600, h);
      meas(512, h);
      `CHK(h, he[k])
    end
    wr(12'h000, 32'h1, r);
    wr(12'h004, 32'h80, r);
    meas(2100, h);
    meas(2048, h);
    `CHK(h, 1024)
    wr(12'h000, 32'h0, r);
    meas(600, h);
    $display("pwm done");
    @(posedge clk);
    open_lamp <= 1'b1;
    meas(48, h);
    `CHK(irq, 1'b0)
    wirq(20);
    meas(1024, h);
    `CHK(h, 0)
    @(posedge clk);
    open_lamp <= 1'b0;
    rd(12'h010, d, r);
    `CHK(d[1:0], 2'h3)
    meas(1024, h);
    `CHK(h, 0)
    wr(12'h018, 32'h1, r);
    meas(3, h);
    `CHK(irq, 1'b0)
    wr(12'h00c, 32'hc8, r);
    wr(12'h01c, 32'h0, r);
    open_lamp <= 1'b1;
    enable <= 1'b0;
    repeat (4) @(posedge clk);
    enable <= 1'b1;
    rd(12'h010, d, r);
    `CHK(d[1:0], 2'h1)
    meas(150, h);
    rd(12'h010, d, r);
    `CHK(d[1:0], 2'h1)
    meas(300, h);
    `CHK(irq, 1'b0)
    rd(12'h014, d, r);
    `CHK(d, 32'h0000_0007)
    wr(12'h01c, 32'h1, r);
    wirq(5);
    wr(12'h018, 32'h1, r);
    wr(12'h004, 32'h19, r);
    supply_good <= 1'b0;
    repeat (4) @(posedge clk);
    supply_good <= 1'b1;
    rd(12'h010, d, r);
    `CHK(d[1:0], 2'h1)
    meas(400, h);
    rd(12'h010, d, r);
    `CHK(d[1:0], 2'h2)
    `CHK(irq, 1'b0)
    wr(12'h004, 32'h1a, r);
    wirq(60);
    $display("fault done");
    stop_test();
  end
endmodule : tb
